// file: core/rac_pkg.sv
// Purpose: constants for the radio adapter configuration registers
// Assumes: 100 MHz clock, 5-bit register address, 8-bit data
// Notes: addresses are the decimal register numbers of the serial port
package rac_pkg;
	localparam logic [4:0] ADDR_STROBE_START = 5'h08;
	localparam logic [4:0] ADDR_STROBE_WIDTH = 5'h09;
	localparam logic [4:0] ADDR_SWITCH_START = 5'h0a;
	localparam logic [4:0] ADDR_SLICER_START = 5'h0b;
	localparam logic [4:0] ADDR_PULSE_DELAY = 5'h0c;
	localparam logic [4:0] ADDR_MEASURE_POS = 5'h0d;
	localparam logic [4:0] ADDR_STATIC_LOW = 5'h0e;
	localparam logic [4:0] ADDR_STATIC_MID = 5'h0f;
	localparam logic [4:0] ADDR_STATIC_HIGH = 5'h10;
	localparam logic [4:0] ADDR_CHANNEL = 5'h12;
	localparam logic [4:0] ADDR_CONTROL = 5'h16;
	localparam logic [4:0] ADDR_PA_LEVEL = 5'h18;
	localparam logic [4:0] ADDR_ENABLE = 5'h19;
	localparam logic [4:0] ADDR_BIAS_DELAY = 5'h1a;
	localparam logic [4:0] ADDR_TABLE_PORT = 5'h1c;
	localparam logic [4:0] ADDR_RX_OFFSET = 5'h1e;
	localparam logic [4:0] ADDR_TX_OFFSET = 5'h1f;

	localparam logic [7:0] RST_STROBE_START = 8'h0c;
	localparam logic [7:0] RST_STROBE_WIDTH = 8'hc8;
	localparam logic [7:0] RST_SWITCH_START = 8'h64;
	localparam logic [7:0] RST_SLICER_START = 8'h0a;
	localparam logic [7:0] RST_PULSE_DELAY = 8'h02;
	localparam logic [7:0] RST_MEASURE_POS = 8'h64;
	localparam logic [7:0] RST_STATIC_LOW = 8'h24;
	localparam logic [7:0] RST_STATIC_MID = 8'h12;
	localparam logic [7:0] RST_STATIC_HIGH = 8'h00;
	localparam logic [7:0] RST_BIAS_DELAY = 8'h64;
	localparam logic [7:0] RST_RX_OFFSET = 8'h61;
	localparam logic [7:0] RST_TX_OFFSET = 8'h60;
	localparam logic [7:0] RST_ZERO = 8'h00;

	localparam int CHAN_DIR_BIT = 7;
	localparam int ENABLE_GRST_BIT = 6;
	localparam logic [11:0] DIVIDER_BASE = 12'h900;
	localparam int TABLE_DEPTH = 13;
	localparam logic [3:0] TABLE_LAST = 4'hc;
	localparam logic [103:0] TABLE_RESET =
		104'h91_90_8e_89_81_74_64_54_47_3e_3a_38_37;

	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1;
	localparam logic [6:0] TICK_CYCLES = 7'(CLK_MHZ * TICK_US);
	localparam logic [8:0] MEASURE_GUARD_US = 9'h00a;
	localparam logic [8:0] ELAPSED_MAX = 9'h1ff;
endpackage

// file: core/rac_regs.sv
// Purpose: configuration registers and slot timing of a radio adapter
// Assumes: serial port decoded outside into address, data and strobes
// Notes: all outputs registered; one microsecond tick restarts at packet start
`timescale 1ns/1ps
module rac_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic pkt_start,
	input wire logic pkt_end,
	input wire logic adc_done,
	input wire logic [7:0] adc_data,
	input wire logic [3:0] table_raddr,
	output logic [7:0] table_rdata,
	output logic [31:0] prog_word,
	output logic [11:0] divider,
	output logic [7:0] pa_level,
	output logic [7:0] enable_bits,
	output logic [7:0] control_bits,
	output logic strobe_en,
	output logic strobe_pulse,
	output logic switch_en,
	output logic slicer_ctrl,
	output logic bias_en,
	output logic adc_start
);
	import rac_pkg::*;

	logic [7:0] strobe_start_delay;
	logic [7:0] strobe_width;
	logic [7:0] switch_start_delay;
	logic [7:0] slicer_ctrl_start_delay;
	logic [7:0] strobe_pulse_delay;
	logic [7:0] strength_measure_position;
	logic [7:0] static_word_low;
	logic [7:0] static_word_mid;
	logic [7:0] static_word_high;
	logic [7:0] channel_word;
	logic [7:0] signal_strength_result;
	logic [7:0] modulator_bias_delay;
	logic [7:0] rx_channel_offset;
	logic [7:0] tx_channel_offset;
	logic [7:0] shaping_table [TABLE_DEPTH];
	logic [3:0] table_ptr;
	logic [7:0] strength_pending;
	logic pending_valid;

	logic in_pkt;
	logic pkt_rx;
	logic [6:0] prescale;
	logic [8:0] elapsed;
	logic [8:0] strobe_end;
	logic strobe_fallen;
	logic [8:0] since_fall;
	logic measure_done;
	logic [11:0] next_divider;

	function automatic logic at_or_past(input logic [8:0] now, input logic [7:0] mark);
		at_or_past = now >= {1'b0, mark};
	endfunction

	function automatic logic [11:0] add_divider(input logic [6:0] chan,
		input logic [7:0] offs);
		add_divider = DIVIDER_BASE + {5'h00, chan} + {4'h0, offs};
	endfunction

	wire wr_hit = reg_wr;

	// timing and static registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strobe_start_delay <= RST_STROBE_START;
			strobe_width <= RST_STROBE_WIDTH;
			switch_start_delay <= RST_SWITCH_START;
			slicer_ctrl_start_delay <= RST_SLICER_START;
			strobe_pulse_delay <= RST_PULSE_DELAY;
			strength_measure_position <= RST_MEASURE_POS;
			static_word_low <= RST_STATIC_LOW;
			static_word_mid <= RST_STATIC_MID;
			static_word_high <= RST_STATIC_HIGH;
			modulator_bias_delay <= RST_BIAS_DELAY;
			rx_channel_offset <= RST_RX_OFFSET;
			tx_channel_offset <= RST_TX_OFFSET;
			channel_word <= RST_ZERO;
			control_bits <= RST_ZERO;
			enable_bits <= RST_ZERO;
			pa_level <= RST_ZERO;
		end else if (wr_hit) begin
			unique case (reg_addr)
				ADDR_STROBE_START: strobe_start_delay <= reg_wdata;
				ADDR_STROBE_WIDTH: strobe_width <= reg_wdata;
				ADDR_SWITCH_START: switch_start_delay <= reg_wdata;
				ADDR_SLICER_START: slicer_ctrl_start_delay <= reg_wdata;
				ADDR_PULSE_DELAY: strobe_pulse_delay <= reg_wdata;
				ADDR_MEASURE_POS: strength_measure_position <= reg_wdata;
				ADDR_STATIC_LOW: static_word_low <= reg_wdata;
				ADDR_STATIC_MID: static_word_mid <= reg_wdata;
				ADDR_STATIC_HIGH: static_word_high <= reg_wdata;
				ADDR_BIAS_DELAY: modulator_bias_delay <= reg_wdata;
				ADDR_RX_OFFSET: rx_channel_offset <= reg_wdata;
				ADDR_TX_OFFSET: tx_channel_offset <= reg_wdata;
				ADDR_CHANNEL: channel_word <= reg_wdata;
				ADDR_CONTROL: control_bits <= reg_wdata;
				// table reset bit is an action, never stored
				ADDR_ENABLE: enable_bits <= reg_wdata & ~(8'h01 << ENABLE_GRST_BIT);
				ADDR_PA_LEVEL: pa_level <= reg_wdata;
				default: ;
			endcase
		end
	end

	// shaping table with saturating write pointer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			table_ptr <= 4'h0;
			for (int i = 0; i < TABLE_DEPTH; i++) begin
				shaping_table[i] <= TABLE_RESET[i*8 +: 8];
			end
		end else if (wr_hit && reg_addr == ADDR_ENABLE && reg_wdata[ENABLE_GRST_BIT]) begin
			table_ptr <= 4'h0;
		end else if (wr_hit && reg_addr == ADDR_TABLE_PORT) begin
			shaping_table[table_ptr] <= reg_wdata;
			if (table_ptr != TABLE_LAST) begin
				table_ptr <= table_ptr + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			table_rdata <= RST_ZERO;
		end else if (table_raddr <= TABLE_LAST) begin
			table_rdata <= shaping_table[table_raddr];
		end else begin
			table_rdata <= RST_ZERO;
		end
	end

	// read mux; write-only and unmapped addresses read zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_STROBE_START: reg_rdata <= strobe_start_delay;
				ADDR_STROBE_WIDTH: reg_rdata <= strobe_width;
				ADDR_SWITCH_START: reg_rdata <= switch_start_delay;
				ADDR_SLICER_START: reg_rdata <= slicer_ctrl_start_delay;
				ADDR_PULSE_DELAY: reg_rdata <= strobe_pulse_delay;
				ADDR_MEASURE_POS: reg_rdata <= strength_measure_position;
				ADDR_STATIC_LOW: reg_rdata <= static_word_low;
				ADDR_STATIC_MID: reg_rdata <= static_word_mid;
				ADDR_STATIC_HIGH: reg_rdata <= static_word_high;
				ADDR_CHANNEL: reg_rdata <= signal_strength_result;
				ADDR_CONTROL: reg_rdata <= control_bits;
				ADDR_PA_LEVEL: reg_rdata <= pa_level;
				ADDR_ENABLE: reg_rdata <= enable_bits;
				ADDR_BIAS_DELAY: reg_rdata <= modulator_bias_delay;
				ADDR_TABLE_PORT: reg_rdata <= shaping_table[table_ptr];
				default: reg_rdata <= RST_ZERO;
			endcase
		end
	end

	// transceiver word; divider sum per direction
	always_comb begin
		if (channel_word[CHAN_DIR_BIT]) begin
			next_divider = add_divider(channel_word[6:0], rx_channel_offset);
		end else begin
			next_divider = add_divider(channel_word[6:0], tx_channel_offset);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divider <= 12'h000;
			prog_word <= 32'h0000_0000;
		end else begin
			divider <= next_divider;
			prog_word <= {static_word_high, static_word_mid, static_word_low[7:1],
				channel_word[CHAN_DIR_BIT], next_divider[7:0]};
		end
	end

	// packet microsecond timebase, restarted at each packet start
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			in_pkt <= 1'b0;
			pkt_rx <= 1'b0;
			prescale <= 7'h00;
			elapsed <= 9'h000;
		end else if (pkt_start) begin
			in_pkt <= 1'b1;
			pkt_rx <= channel_word[CHAN_DIR_BIT];
			prescale <= 7'h00;
			elapsed <= 9'h000;
		end else if (pkt_end) begin
			in_pkt <= 1'b0;
		end else if (in_pkt) begin
			if (prescale == TICK_CYCLES - 7'h01) begin
				prescale <= 7'h00;
				if (elapsed != ELAPSED_MAX) begin
					elapsed <= elapsed + 9'h001;
				end
			end else begin
				prescale <= prescale + 7'h01;
			end
		end
	end

	// the output flop adds one cycle, well inside the allowed microsecond slack
	assign strobe_end = 9'({1'b0, strobe_start_delay} + {1'b0, strobe_width});

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strobe_en <= 1'b0;
			strobe_pulse <= 1'b0;
			switch_en <= 1'b0;
			slicer_ctrl <= 1'b0;
			bias_en <= 1'b0;
		end else begin
			strobe_en <= in_pkt && at_or_past(elapsed, strobe_start_delay)
				&& !(elapsed >= strobe_end);
			// end mark kept in nine bits so a count of 255 still gives a pulse
			strobe_pulse <= in_pkt && at_or_past(elapsed, strobe_pulse_delay)
				&& elapsed < 9'({1'b0, strobe_pulse_delay} + 9'h001);
			switch_en <= in_pkt && at_or_past(elapsed, switch_start_delay);
			slicer_ctrl <= in_pkt && pkt_rx
				&& elapsed > {1'b0, slicer_ctrl_start_delay};
			bias_en <= in_pkt && !pkt_rx && at_or_past(elapsed, modulator_bias_delay);
		end
	end

	// guard time counted from the strobe falling edge
	always_ff @(posedge clk) begin
		if (!rst_n || pkt_start) begin
			strobe_fallen <= 1'b0;
			since_fall <= 9'h000;
		end else if (in_pkt && elapsed >= strobe_end && elapsed != 9'h000) begin
			strobe_fallen <= 1'b1;
			if (strobe_fallen && prescale == TICK_CYCLES - 7'h01
				&& since_fall != ELAPSED_MAX) begin
				since_fall <= since_fall + 9'h001;
			end
		end
	end

	// one conversion per receive packet; result published at packet end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			adc_start <= 1'b0;
			measure_done <= 1'b0;
			pending_valid <= 1'b0;
			strength_pending <= RST_ZERO;
			signal_strength_result <= RST_ZERO;
		end else begin
			adc_start <= 1'b0;
			if (pkt_start) begin
				measure_done <= 1'b0;
				pending_valid <= 1'b0;
			end else if (in_pkt && pkt_rx && !measure_done
				&& at_or_past(elapsed, strength_measure_position)
				&& strobe_fallen && since_fall >= MEASURE_GUARD_US) begin
				adc_start <= 1'b1;
				measure_done <= 1'b1;
			end
			if (adc_done && measure_done) begin
				strength_pending <= adc_data;
				pending_valid <= 1'b1;
			end
			// readable only after the packet ends
			if (pkt_end && pending_valid) begin
				signal_strength_result <= strength_pending;
			end
		end
	end
endmodule

// file: test/rac_regs_asserts.sv
// Purpose: port checks for rac_regs
// Assumes: mirrors of written registers start from reset values
// Notes: guards skip the edge after a write, where outputs still lag
`timescale 1ns/1ps
module rac_regs_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic pkt_start,
	input wire logic [31:0] prog_word,
	input wire logic [11:0] divider,
	input wire logic [7:0] pa_level,
	input wire logic strobe_en,
	input wire logic slicer_ctrl,
	input wire logic bias_en,
	input wire logic adc_start
);
	import rac_pkg::*;
	logic [7:0] lo, mid, hi, rxo, txo, ch;
	logic rx_pkt;
	logic [10:0] since;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lo <= RST_STATIC_LOW;
			mid <= RST_STATIC_MID;
			hi <= RST_STATIC_HIGH;
			rxo <= RST_RX_OFFSET;
			txo <= RST_TX_OFFSET;
			ch <= RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_STATIC_LOW: lo <= reg_wdata;
				ADDR_STATIC_MID: mid <= reg_wdata;
				ADDR_STATIC_HIGH: hi <= reg_wdata;
				ADDR_RX_OFFSET: rxo <= reg_wdata;
				ADDR_TX_OFFSET: txo <= reg_wdata;
				ADDR_CHANNEL: ch <= reg_wdata;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n)
			rx_pkt <= 1'b0;
		else if (pkt_start)
			rx_pkt <= ch[7];
	end
	// restarts at packet start too, so a missing strobe cannot hide an early start
	always_ff @(posedge clk) begin
		if (!rst_n || pkt_start || $fell(strobe_en))
			since <= 11'h000;
		else if (since != 11'h7ff)
			since <= since + 11'h001;
	end
	pa_follow_a: assert property (reg_wr && reg_addr == ADDR_PA_LEVEL |=>
		pa_level == $past(reg_wdata)) else $error("pa level not updated");
	div_form_a: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(reg_wr) |->
		divider == DIVIDER_BASE + {5'h00, ch[6:0]} + {4'h0, ch[7] ? rxo : txo})
		else $error("divider sum wrong");
	static_map_a: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(reg_wr) |->
		prog_word[31:9] == {hi, mid, lo[7:1]}) else $error("static field wrong");
	word_low_a: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(reg_wr) |->
		prog_word[8:0] == {ch[7], divider[7:0]}) else $error("slot field wrong");
	wo_read_a: assert property (reg_rd && reg_addr[4:1] == 4'hf |=> reg_rdata == 8'h00)
		else $error("offset readable");
	adc_rx_a: assert property (adc_start |-> rx_pkt) else $error("measure in tx");
	adc_guard_a: assert property (adc_start |-> since >= 11'h3de)
		else $error("measure too early");
	bias_tx_a: assert property (bias_en |-> !rx_pkt) else $error("bias in rx");
	slicer_rx_a: assert property (slicer_ctrl |-> rx_pkt) else $error("slicer in tx");
endmodule
bind rac_regs rac_regs_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pkt_start(pkt_start), .prog_word(prog_word), .divider(divider), .pa_level(pa_level),
	.strobe_en(strobe_en), .slicer_ctrl(slicer_ctrl), .bias_en(bias_en), .adc_start(adc_start));

// file: test/rac_front_model.sv
// Purpose: signal-strength converter on the transceiver side
// Assumes: one conversion per adc_start
// Notes: data wanders outside done so a stale value never looks valid
`timescale 1ns/1ps
module rac_front_model #(
	parameter int LAT = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic adc_start,
	input wire logic [7:0] level,
	output logic adc_done,
	output logic [7:0] adc_data
);
	int cnt;
	always_ff @(posedge clk) begin
		adc_done <= 1'b0;
		adc_data <= rst_n ? adc_data + 8'h5b : 8'h00;
		if (!rst_n)
			cnt <= 0;
		else if (adc_start)
			cnt <= LAT;
		else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				adc_done <= 1'b1;
				adc_data <= level;
			end
		end
	end
endmodule

// file: test/radio_adapter_config_regs_tb.sv
// Purpose: self-checking bench for rac_regs
// Assumes: inputs change 1 ns after the rising edge
// Notes: slot timing judged within one microsecond of slack
`timescale 1ns/1ps
module radio_adapter_config_regs_tb;
	import rac_pkg::*;
	localparam logic [7:0] RV [9] = '{8'h0c, 8'hc8, 8'h64, 8'h0a, 8'h02, 8'h64, 8'h24, 8'h12, 8'h00};
	localparam logic [7:0] TV [6] = '{8'h02, 8'h03, 8'h04, 8'h01, 8'h03, 8'h05};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00, level = 8'h77, adc_data, reg_rdata, table_rdata, pa_level;
	logic [7:0] enable_bits, control_bits;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pkt_start = 1'b0, pkt_end = 1'b0, adc_done;
	logic strobe_en, strobe_pulse, switch_en, slicer_ctrl, bias_en, adc_start;
	logic [3:0] table_raddr = 4'h0;
	logic [31:0] prog_word;
	logic [11:0] divider;
	int n_fail = 0, num_checks = 0, cyc = 0;
	int t [7];
	always #5 clk = ~clk;
	rac_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_start(pkt_start),
		.pkt_end(pkt_end), .adc_done(adc_done), .adc_data(adc_data), .table_raddr(table_raddr),
		.table_rdata(table_rdata), .prog_word(prog_word), .divider(divider), .pa_level(pa_level),
		.enable_bits(enable_bits), .control_bits(control_bits), .strobe_en(strobe_en),
		.strobe_pulse(strobe_pulse), .switch_en(switch_en), .slicer_ctrl(slicer_ctrl),
		.bias_en(bias_en), .adc_start(adc_start));
	rac_front_model #(.LAT(20)) i_front (.clk(clk), .rst_n(rst_n), .adc_start(adc_start),
		.level(level), .adc_done(adc_done), .adc_data(adc_data));
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
	endtask
	function automatic logic inr(int v, int lo, int hi);
		return v >= lo && v <= hi;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		tick(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		tick(1);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask
	task automatic t_reset;
		for (int i = 0; i < 9; i++)
			rd(5'(8 + i), RV[i]);
		rd(ADDR_BIAS_DELAY, 8'h64);
		rd(ADDR_RX_OFFSET, 8'h00);
		rd(ADDR_CHANNEL, 8'h00);
		rd(5'h11, 8'h00);
		chk(divider, 12'h960);
		chk(prog_word, 32'h0012_2460);
		for (int i = 0; i < 14; i++) begin
			table_raddr = 4'(i);
			tick(1);
			chk(table_rdata, i < 13 ? TABLE_RESET[i * 8 +: 8] : 8'h00);
		end
	endtask
	task automatic t_conv;
		wr(ADDR_TX_OFFSET, 8'hff);
		wr(ADDR_RX_OFFSET, 8'h00);
		wr(ADDR_CHANNEL, 8'h7f);
		tick(2);
		chk(divider, 12'ha7e);
		chk(prog_word[8:0], 9'h07e);
		wr(ADDR_CHANNEL, 8'h85);
		tick(2);
		chk(divider, 12'h905);
		chk(prog_word[8:0], 9'h105);
		rd(ADDR_TX_OFFSET, 8'h00);
	endtask
	task automatic t_static;
		wr(ADDR_STATIC_LOW, 8'hff);
		wr(ADDR_STATIC_MID, 8'ha5);
		wr(ADDR_STATIC_HIGH, 8'h3c);
		wr(ADDR_CHANNEL, 8'h00);
		tick(2);
		chk(prog_word, 32'h3ca5_feff);
	endtask
	task automatic t_pa;
		wr(ADDR_PA_LEVEL, 8'h5a);
		chk(pa_level, 8'h5a);
		rd(ADDR_PA_LEVEL, 8'h5a);
		wr(ADDR_CONTROL, 8'h04);
		chk(control_bits, 8'h04);
		rd(ADDR_CONTROL, 8'h04);
	endtask
	task automatic t_table;
		wr(ADDR_ENABLE, 8'hff);
		chk(enable_bits, 8'hbf);
		rd(ADDR_ENABLE, 8'hbf);
		wr(ADDR_ENABLE, 8'h40);
		chk(enable_bits[6], 1'b0);
		for (int i = 0; i < 15; i++)
			wr(ADDR_TABLE_PORT, 8'(8'ha0 + i));
		rd(ADDR_TABLE_PORT, 8'hae);
		for (int i = 0; i < 13; i++) begin
			table_raddr = 4'(i);
			tick(1);
			chk(table_rdata, i < 12 ? 8'(8'ha0 + i) : 8'hae);
		end
		wr(ADDR_ENABLE, 8'h40);
		wr(ADDR_TABLE_PORT, 8'h11);
		table_raddr = 4'h0;
		tick(1);
		chk(table_rdata, 8'h11);
	endtask
	task automatic run_pkt(input logic [7:0] ch);
		logic [6:0] s;
		wr(ADDR_CHANNEL, ch);
		tick(2);
		pkt_start = 1'b1;
		tick(1);
		pkt_start = 1'b0;
		foreach (t[k])
			t[k] = -1;
		for (int c = 1; c < 1800; c++) begin
			s = {adc_start, bias_en, slicer_ctrl, switch_en, strobe_pulse, strobe_en, ~strobe_en};
			for (int k = 0; k < 7; k++)
				if (s[k] === 1'b1 && t[k] < 0 && (k > 0 || t[1] >= 0))
					t[k] = c;
			tick(1);
		end
		pkt_end = 1'b1;
		tick(1);
		pkt_end = 1'b0;
		tick(1);
	endtask
	task automatic t_rx;
		for (int i = 0; i < 6; i++)
			wr(5'(8 + i), TV[i]);
		wr(ADDR_BIAS_DELAY, 8'h02);
		run_pkt(8'h80);
		chk(inr(t[1], 200, 302), 1'b1);
		chk(inr(t[0] - t[1], 298, 302), 1'b1);
		chk(inr(t[2], 300, 402), 1'b1);
		chk(inr(t[3], 400, 502), 1'b1);
		chk(inr(t[4], 198, 202), 1'b1);
		chk(inr(t[6] - t[0], 990, 1110), 1'b1);
		chk(t[5], -1);
		rd(ADDR_CHANNEL, 8'h77);
	endtask
	task automatic t_tx;
		level = 8'h22;
		run_pkt(8'h00);
		chk(inr(t[5], 200, 302), 1'b1);
		chk(t[6], -1);
		rd(ADDR_CHANNEL, 8'h77);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset;
		$display("reset values done");
		t_conv;
		$display("channel conversion done");
		t_static;
		$display("static word done");
		t_pa;
		$display("power level done");
		t_table;
		$display("shaping table done");
		t_rx;
		$display("receive packet done");
		t_tx;
		$display("transmit packet done");
		final_report;
	end
endmodule
